//--- rtl/timer16_pkg.sv
// Package with register map, field positions and constants of the 16-bit capture/reload timer
package timer16_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h1;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h2;
  localparam logic [3:0] ADDR_CAPTURE_LOW = 4'h3;
  localparam logic [3:0] ADDR_CAPTURE_HIGH = 4'h4;
  localparam logic [3:0] ADDR_CLKDIV = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
  // Control register bit positions
  localparam int unsigned BIT_OVERFLOW = 7;
  localparam int unsigned BIT_EXT_EVENT = 6;
  localparam int unsigned BIT_RX_BAUD = 5;
  localparam int unsigned BIT_TX_BAUD = 4;
  localparam int unsigned BIT_EXT_EN = 3;
  localparam int unsigned BIT_RUN = 2;
  localparam int unsigned BIT_CLK_SRC = 1;
  localparam int unsigned BIT_CAP_RL = 0;
  // Clock divider register: prescale_select position
  localparam int unsigned BIT_PRESCALE = 0;
  // Interrupt status / mask bit positions
  localparam int unsigned IRQ_OVERFLOW = 0;
  localparam int unsigned IRQ_EXT_EVENT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CLKDIV_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [3:0] PRESCALE_DIV = 4'hc;
  localparam logic [3:0] BAUD_DIV = 4'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic overflow;
    logic ext_event;
    logic rx_baud;
    logic tx_baud;
    logic ext_en;
    logic run;
    logic clk_src;
    logic cap_rl;
  } ctrl_s;

  typedef enum logic [1:0] {MODE_OFF, MODE_CAPTURE, MODE_RELOAD, MODE_BAUD} mode_e;
endpackage : timer16_pkg

//--- rtl/capture_reload_timer16.sv
// 16-bit counter/timer with capture, auto-reload and baud generator modes
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module capture_reload_timer16
  import timer16_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // External pins
  input wire logic count_input_pin,
  input wire logic external_trigger_pin,
  // Serial port shift clock and interrupt
  output logic baud_tick,
  output logic irq
);

  function automatic logic hit(input bus_req_s r, input logic [ADDR_W-1:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  bus_req_s req;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Synchronisers and edge detection
  logic [2:0] cnt_sync_r, cnt_sync_nxt;
  logic [2:0] trg_sync_r, trg_sync_nxt;
  logic cnt_fall, trg_fall;

  always_comb begin
    cnt_sync_nxt = {cnt_sync_r[1:0], count_input_pin};
    trg_sync_nxt = {trg_sync_r[1:0], external_trigger_pin};
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_sync_r <= 3'h7;
      trg_sync_r <= 3'h7;
    end else begin
      cnt_sync_r <= cnt_sync_nxt;
      trg_sync_r <= trg_sync_nxt;
    end
  end

  assign cnt_fall = cnt_sync_r[2] && !cnt_sync_r[1];
  assign trg_fall = trg_sync_r[2] && !trg_sync_r[1];

  // Registers
  ctrl_s ctrl_r, ctrl_nxt;
  logic [7:0] clkdiv_r, clkdiv_nxt;
  logic [7:0] count_low_byte_r, count_low_byte_nxt;
  logic [7:0] count_high_byte_r, count_high_byte_nxt;
  logic [7:0] capture_low_r, capture_low_nxt;
  logic [7:0] capture_high_r, capture_high_nxt;
  logic [1:0] irq_mask_r, irq_mask_nxt;
  logic [3:0] pre_r, pre_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic baud_tick_r, baud_tick_nxt;

  mode_e mode;
  logic [15:0] count;
  logic [15:0] capture;
  logic [3:0] div;
  logic tick;
  logic wrap;
  logic trig;
  logic set_ovf;
  logic set_ext;

  assign count = {count_high_byte_r, count_low_byte_r};
  assign capture = {capture_high_r, capture_low_r};

  always_comb begin
    if (!ctrl_r.run) begin
      mode = MODE_OFF;
    end else if (ctrl_r.rx_baud || ctrl_r.tx_baud) begin
      mode = MODE_BAUD;
    end else if (ctrl_r.cap_rl) begin
      mode = MODE_CAPTURE;
    end else begin
      mode = MODE_RELOAD;
    end
  end

  always_comb begin
    if (mode == MODE_BAUD) begin
      div = BAUD_DIV;
    end else if (clkdiv_r[BIT_PRESCALE]) begin
      div = 4'h1;
    end else begin
      div = PRESCALE_DIV;
    end
  end

  always_comb begin
    pre_nxt = pre_r;
    tick = 1'b0;
    if (mode == MODE_OFF || ctrl_r.clk_src) begin
      pre_nxt = 4'h0;
      tick = (mode != MODE_OFF) && cnt_fall;
    end else if (pre_r + 4'h1 >= div) begin
      pre_nxt = 4'h0;
      tick = 1'b1;
    end else begin
      pre_nxt = pre_r + 4'h1;
    end
  end

  assign wrap = tick && (count == COUNT_MAX);
  assign trig = trg_fall && ctrl_r.ext_en && (mode != MODE_OFF);
  assign set_ovf = wrap && (mode == MODE_CAPTURE || mode == MODE_RELOAD);
  assign set_ext = trig;

  always_comb begin
    logic [15:0] cnt_v;
    logic [15:0] cap_v;
    cnt_v = count;
    cap_v = capture;
    ctrl_nxt = ctrl_r;
    clkdiv_nxt = clkdiv_r;
    irq_mask_nxt = irq_mask_r;
    baud_tick_nxt = 1'b0;
    if (hit(req, ADDR_CTRL)) begin
      ctrl_nxt = ctrl_s'(wdata);
    end
    if (hit(req, ADDR_IRQ_STATUS)) begin
      // Write one clears either flag
      if (wdata[IRQ_OVERFLOW]) begin
        ctrl_nxt.overflow = 1'b0;
      end
      if (wdata[IRQ_EXT_EVENT]) begin
        ctrl_nxt.ext_event = 1'b0;
      end
    end
    if (hit(req, ADDR_CLKDIV)) begin
      clkdiv_nxt = wdata;
    end
    if (hit(req, ADDR_IRQ_MASK)) begin
      irq_mask_nxt = wdata[1:0];
    end
    if (hit(req, ADDR_COUNT_LOW)) begin
      cnt_v[7:0] = wdata;
    end
    if (hit(req, ADDR_COUNT_HIGH)) begin
      cnt_v[15:8] = wdata;
    end
    if (hit(req, ADDR_CAPTURE_LOW)) begin
      cap_v[7:0] = wdata;
    end
    if (hit(req, ADDR_CAPTURE_HIGH)) begin
      cap_v[15:8] = wdata;
    end
    if (tick) begin
      if (wrap && mode != MODE_CAPTURE) begin
        cnt_v = capture;
      end else begin
        cnt_v = count + 16'h0001;
      end
    end
    if (wrap && mode == MODE_BAUD) begin
      baud_tick_nxt = 1'b1;
    end
    if (trig) begin
      if (mode == MODE_CAPTURE) begin
        cap_v = tick ? cnt_v : count;
      end else if (mode == MODE_RELOAD) begin
        cnt_v = capture;
      end
    end
    // Hardware set wins over software clear
    if (set_ovf) begin
      ctrl_nxt.overflow = 1'b1;
    end
    if (set_ext) begin
      ctrl_nxt.ext_event = 1'b1;
    end
    count_low_byte_nxt = cnt_v[7:0];
    count_high_byte_nxt = cnt_v[15:8];
    capture_low_nxt = cap_v[7:0];
    capture_high_nxt = cap_v[15:8];
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (rd) begin
      case (addr)
        ADDR_CTRL: rdata_nxt = ctrl_r;
        ADDR_COUNT_LOW: rdata_nxt = count_low_byte_r;
        ADDR_COUNT_HIGH: rdata_nxt = count_high_byte_r;
        ADDR_CAPTURE_LOW: rdata_nxt = capture_low_r;
        ADDR_CAPTURE_HIGH: rdata_nxt = capture_high_r;
        ADDR_CLKDIV: rdata_nxt = clkdiv_r;
        ADDR_IRQ_STATUS: rdata_nxt = {6'h00, ctrl_r.ext_event, ctrl_r.overflow};
        ADDR_IRQ_MASK: rdata_nxt = {6'h00, irq_mask_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= ctrl_s'(CTRL_RESET);
      clkdiv_r <= CLKDIV_RESET;
      count_low_byte_r <= COUNT_RESET[7:0];
      count_high_byte_r <= COUNT_RESET[15:8];
      capture_low_r <= COUNT_RESET[7:0];
      capture_high_r <= COUNT_RESET[15:8];
      irq_mask_r <= 2'h0;
      pre_r <= 4'h0;
      rdata_r <= 8'h00;
      baud_tick_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      clkdiv_r <= clkdiv_nxt;
      count_low_byte_r <= count_low_byte_nxt;
      count_high_byte_r <= count_high_byte_nxt;
      capture_low_r <= capture_low_nxt;
      capture_high_r <= capture_high_nxt;
      irq_mask_r <= irq_mask_nxt;
      pre_r <= pre_nxt;
      rdata_r <= rdata_nxt;
      baud_tick_r <= baud_tick_nxt;
    end
  end

  assign rdata = rdata_r;
  assign baud_tick = baud_tick_r;
  assign irq = (ctrl_r.overflow && irq_mask_r[IRQ_OVERFLOW])
    || (ctrl_r.ext_event && irq_mask_r[IRQ_EXT_EVENT]);

endmodule : capture_reload_timer16

//--- verif/pin_model.sv
// Far-side model driving the count and trigger pins
`timescale 1ns/10ps
module pin_model (
  // Bench requests and driven pins
  input wire logic sys_clk,
  input wire logic cnt_req,
  input wire logic trg_req,
  output logic count_input_pin,
  output logic external_trigger_pin
);
  logic [2:0] ct_r = 3'h0;
  logic [2:0] tt_r = 3'h0;
  // Pins idle high; a request gives one fall, 3 cycles low then 3 high
  always @(posedge sys_clk) begin
    ct_r <= cnt_req ? 3'h6 : ct_r - {2'h0, ct_r != 3'h0};
    tt_r <= trg_req ? 3'h6 : tt_r - {2'h0, tt_r != 3'h0};
  end
  assign count_input_pin = ct_r < 3'h4;
  assign external_trigger_pin = tt_r < 3'h4;
endmodule : pin_model

//--- verif/timer16_properties.sv
// Port assertions for the timer
`timescale 1ns/10ps
module timer16_properties
  import timer16_pkg::*;
(
  // Watched ports
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic baud_tick,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_rd_idle: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
  a_unmapped_zero: assert property (rd && addr > ADDR_IRQ_MASK |=> rdata == 8'h00)
    else $error("unmapped read");
  a_cap_low: assert property (wr && addr == ADDR_CAPTURE_LOW ##1 rd && $stable(addr)
    |=> rdata == $past(wdata, 2)) else $error("capture low");
  a_cap_high: assert property (wr && addr == ADDR_CAPTURE_HIGH ##1 rd && $stable(addr)
    |=> rdata == $past(wdata, 2)) else $error("capture high");
  a_mask_rw: assert property (wr && addr == ADDR_IRQ_MASK ##1 rd && $stable(addr)
    |=> rdata[1:0] == $past(wdata[1:0], 2)) else $error("mask");
  a_prescale_rw: assert property (wr && addr == ADDR_CLKDIV ##1 rd && $stable(addr)
    |=> rdata[0] == $past(wdata[0], 2)) else $error("prescale");
  a_mask_off: assert property (wr && addr == ADDR_IRQ_MASK && wdata[1:0] == 2'h0
    |=> !irq) else $error("masked irq");
  a_tick_single: assert property (baud_tick |=> !baud_tick) else $error("long tick");
endmodule : timer16_properties

bind capture_reload_timer16 timer16_properties u_props (.sys_clk(sys_clk), .rstn(rstn),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .baud_tick(baud_tick), .irq(irq));

//--- verif/tb.sv
// Self-checking bench for the capture/reload timer
`timescale 1ns/10ps
module tb
  import timer16_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cnt_req = 1'b0;
  logic trg_req = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] rdata;
  logic cpin, tpin, baud_tick, irq;
  logic [7:0] exp_q[$];
  logic [7:0] bm[3] = '{8'h27, 8'h17, 8'h37};
  logic [31:0] rnd = 32'd82401;
  logic [15:0] cap;
  int miscompares = 0;
  int n_tests = 0;
  int ticks = 0;
  int cyc = 0;
  capture_reload_timer16 DUT (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .count_input_pin(cpin), .external_trigger_pin(tpin),
    .baud_tick(baud_tick), .irq(irq));
  pin_model pins (.sys_clk(sys_clk), .cnt_req(cnt_req), .trg_req(trg_req),
    .count_input_pin(cpin), .external_trigger_pin(tpin));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic end_sim();
    $display("compares %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic chk(logic [7:0] g, logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge sys_clk);
  endtask : wr_reg
  task automatic rd_exp(logic [3:0] a, logic [7:0] e);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk);
  endtask : rd_exp
  task automatic rd16(logic [3:0] a, logic [15:0] e);
    rd_exp(a, e[7:0]);
    rd_exp(a + 4'h1, e[15:8]);
  endtask : rd16
  task automatic chk_irq(logic e);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge sys_clk);
    chk({7'h00, irq}, {7'h00, e});
    @(posedge sys_clk);
  endtask : chk_irq
  task automatic pulse(logic trg);
    wr <= 1'b0;
    rd <= 1'b0;
    trg_req <= trg;
    cnt_req <= !trg;
    @(posedge sys_clk);
    trg_req <= 1'b0;
    cnt_req <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : pulse
  // Stop, clear flags, load the count, then apply the mode
  task automatic setup(logic [7:0] c, logic [15:0] v);
    wr_reg(ADDR_CTRL, 8'h00);
    wr_reg(ADDR_COUNT_HIGH, v[15:8]);
    wr_reg(ADDR_COUNT_LOW, v[7:0]);
    wr_reg(ADDR_CTRL, c);
  endtask : setup
  always @(posedge sys_clk) begin
    cyc++;
    if (baud_tick === 1'b1) ticks++;
    if (rd_d) chk(rdata, exp_q.pop_front());
    rd_d <= rd;
    if (cyc == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rd_exp(ADDR_CTRL, CTRL_RESET);
    wr_reg(4'hf, 8'h5a);
    rd_exp(4'hf, 8'h00);
    rd16(ADDR_COUNT_LOW, COUNT_RESET);
    rnd = lfsr(rnd);
    cap = rnd[15:0];
    wr_reg(ADDR_CLKDIV, 8'h01);
    rd_exp(ADDR_CLKDIV, 8'h01);
    wr_reg(ADDR_IRQ_MASK, 8'h03);
    rd_exp(ADDR_IRQ_MASK, 8'h03);
    wr_reg(ADDR_CAPTURE_LOW, cap[7:0]);
    rd_exp(ADDR_CAPTURE_LOW, cap[7:0]);
    wr_reg(ADDR_CAPTURE_HIGH, cap[15:8]);
    rd_exp(ADDR_CAPTURE_HIGH, cap[15:8]);
    setup(8'h07, 16'h0000);
    repeat (5) pulse(1'b0);
    rd16(ADDR_COUNT_LOW, 16'h0005);
    wr_reg(ADDR_CTRL, 8'h0b);
    pulse(1'b0);
    pulse(1'b1);
    rd16(ADDR_COUNT_LOW, 16'h0005);
    wr_reg(ADDR_CTRL, 8'h07);
    pulse(1'b1);
    rd16(ADDR_CAPTURE_LOW, cap);
    wr_reg(ADDR_CTRL, 8'h0f);
    pulse(1'b1);
    rd16(ADDR_CAPTURE_LOW, 16'h0005);
    rd_exp(ADDR_CTRL, 8'h4f);
    chk_irq(1'b1);
    wr_reg(ADDR_IRQ_STATUS, 8'h02);
    chk_irq(1'b0);
    setup(8'h07, 16'hffff);
    pulse(1'b0);
    rd16(ADDR_COUNT_LOW, 16'h0000);
    rd_exp(ADDR_IRQ_STATUS, 8'h01);
    chk_irq(1'b1);
    wr_reg(ADDR_IRQ_MASK, 8'h00);
    chk_irq(1'b0);
    wr_reg(ADDR_IRQ_MASK, 8'h03);
    wr_reg(ADDR_CAPTURE_LOW, cap[7:0]);
    wr_reg(ADDR_CAPTURE_HIGH, cap[15:8]);
    setup(8'h06, 16'hffff);
    pulse(1'b0);
    rd16(ADDR_COUNT_LOW, cap);
    rd_exp(ADDR_IRQ_STATUS, 8'h01);
    setup(8'h06, 16'h1234);
    pulse(1'b1);
    rd16(ADDR_COUNT_LOW, 16'h1234);
    wr_reg(ADDR_CTRL, 8'h0e);
    pulse(1'b1);
    rd16(ADDR_COUNT_LOW, cap);
    chk_irq(1'b1);
    foreach (bm[i]) begin
      setup(bm[i], 16'hffff);
      pulse(1'b0);
      rd16(ADDR_COUNT_LOW, cap);
      chk_irq(1'b0);
    end
    // Internal source: ten edges undivided, 28 edges at /12, ten edges in baud mode
    setup(8'h05, 16'h0000);
    pulse(1'b0);
    wr_reg(ADDR_CTRL, 8'h00);
    rd16(ADDR_COUNT_LOW, 16'h000a);
    wr_reg(ADDR_CLKDIV, 8'h00);
    setup(8'h05, 16'h0000);
    repeat (3) pulse(1'b0);
    wr_reg(ADDR_CTRL, 8'h00);
    rd16(ADDR_COUNT_LOW, 16'h0002);
    setup(8'h24, 16'h0000);
    pulse(1'b0);
    wr_reg(ADDR_CTRL, 8'h00);
    rd16(ADDR_COUNT_LOW, 16'h0005);
    chk(ticks[7:0], 8'h03);
    end_sim();
  end
endmodule : tb
